// ### core/rtc_nvram.sv
// bytewide ram with timekeeping registers in the top eight bytes
module rtc_nvram
  import rtc_pkg::*;
#(
  parameter int SECOND_PERIOD = rtc_pkg::SECOND_CYCLES,
  parameter int TEST_PERIOD = rtc_pkg::TEST_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [rtc_pkg::ADDR_W-1:0] addr,
  input wire logic select_n,
  input wire logic drive_n,
  input wire logic strobe_n,
  input wire logic [rtc_pkg::DATA_W-1:0] data_in,
  output logic [rtc_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic power_fail,
  input wire logic battery_good
);
  import rtc_pkg::*;

  initial begin
    if (SECOND_PERIOD < 2 * TEST_PERIOD || TEST_PERIOD < 1) begin
      $error("rtc_nvram timing parameters inconsistent");
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // no calibration: the second tick is a plain fixed divider
  logic [7:0] ram [0:2039];
  time_s counters;
  time_s visible;
  logic write_halt;
  logic read_freeze;
  logic timebase_stop;
  logic freq_test;
  logic sec_tick;
  logic test_tick;
  logic test_phase;
  logic halted;

  // accesses only count while power is good
  logic sel_ok;
  logic rd_mode;
  logic wr_mode;
  logic wr_mode_d;
  logic write_halt_d;
  logic wr_start;
  assign sel_ok = !select_n && !power_fail;
  assign rd_mode = sel_ok && !drive_n && strobe_n;
  assign wr_mode = sel_ok && !strobe_n;
  // write begins at the later falling edge
  assign wr_start = wr_mode && !wr_mode_d;
  assign halted = write_halt || read_freeze;

  rate_divider #(.PERIOD(SECOND_PERIOD)) second_div (
    .clock(clock),
    .rst_n(rst_n),
    .run(!timebase_stop),
    .pulse(sec_tick)
  );

  // half period of the 512 Hz test toggle
  rate_divider #(.PERIOD(TEST_PERIOD)) test_div (
    .clock(clock),
    .rst_n(rst_n),
    .run(!timebase_stop && freq_test),
    .pulse(test_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // calendar carry chain
  logic [7:0] month_len;
  logic leap;
  logic [7:0] nx_sec, nx_min, nx_hour, nx_wday, nx_date, nx_mon, nx_year;
  logic [7:0] nx_cent;
  logic w_sec, w_min, w_hour, w_wday, w_date, w_mon, w_year, w_cent;

  // leap year: bcd year divisible by four
  assign leap = (counters.year[4] ? counters.year[1:0] == 2'b10
                                  : counters.year[1:0] == 2'b00);
  always_comb begin
    case (counters.month)
      8'h02: month_len = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  end

  bcd_step step_sec (.value(counters.seconds & MASK_SECONDS),
    .max_value(8'h59), .min_value(8'h00), .next_value(nx_sec),
    .wrap(w_sec));
  bcd_step step_min (.value(counters.minutes), .max_value(8'h59),
    .min_value(8'h00), .next_value(nx_min), .wrap(w_min));
  bcd_step step_hour (.value(counters.hour), .max_value(8'h23),
    .min_value(8'h00), .next_value(nx_hour), .wrap(w_hour));
  bcd_step step_wday (.value(counters.weekday & MASK_WEEKDAY),
    .max_value(8'h07), .min_value(8'h01), .next_value(nx_wday),
    .wrap(w_wday));
  bcd_step step_date (.value(counters.date), .max_value(month_len),
    .min_value(8'h01), .next_value(nx_date), .wrap(w_date));
  bcd_step step_mon (.value(counters.month), .max_value(8'h12),
    .min_value(8'h01), .next_value(nx_mon), .wrap(w_mon));
  bcd_step step_year (.value(counters.year), .max_value(8'h99),
    .min_value(8'h00), .next_value(nx_year), .wrap(w_year));
  bcd_step step_cent (.value(counters.century), .max_value(8'h39),
    .min_value(8'h00), .next_value(nx_cent), .wrap(w_cent));

  time_s next_counters;
  always_comb begin
    next_counters = counters;
    next_counters.seconds = {counters.seconds[7], nx_sec[6:0]};
    if (w_sec) begin
      next_counters.minutes = nx_min;
      if (w_min) begin
        next_counters.hour = nx_hour;
        if (w_hour) begin
          next_counters.weekday = nx_wday;
          next_counters.date = nx_date;
          if (w_date) begin
            next_counters.month = nx_mon;
            if (w_mon) begin
              next_counters.year = nx_year;
              if (w_year) begin
                next_counters.century = nx_cent;
              end
            end
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counters and ram hold across power fail; no reset clears ram
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      counters <= TIME_RESET;
    end else if (write_halt && wr_start) begin
      // loaded values go to the visible copy first
      counters <= counters;
    end else if (halted && !write_halt && sec_tick) begin
      // counting continues behind a frozen view
      counters <= next_counters;
    end else if (!halted && write_halt_d) begin
      // clearing the write bit with the read bit also clear transfers the loaded values
      counters <= visible;
    end else if (sec_tick) begin
      // counting runs on each tick except in a write cycle under write halt or in the transfer cycle
      counters <= next_counters;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      write_halt_d <= 1'b0;
      wr_mode_d <= 1'b0;
    end else begin
      write_halt_d <= write_halt;
      wr_mode_d <= wr_mode;
    end
  end

  // visible copy tracks the counters unless halted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      visible <= TIME_RESET;
    end else if (wr_start && addr >= REG_SECONDS && write_halt) begin
      case (addr)
        REG_SECONDS: visible.seconds <= data_in & MASK_SECONDS;
        REG_MINUTES: visible.minutes <= data_in & MASK_MINUTES;
        REG_HOUR: visible.hour <= data_in & MASK_HOUR;
        REG_WEEKDAY: visible.weekday <= data_in & MASK_WEEKDAY;
        REG_DATE: visible.date <= data_in & MASK_DATE;
        REG_MONTH: visible.month <= data_in & MASK_MONTH;
        default: visible.year <= data_in;
      endcase
    end else if (wr_start && addr == REG_CONTROL && write_halt) begin
      visible.century <= data_in & MASK_CENTURY;
    end else if (!halted) begin
      visible <= counters;
    end
  end

  // control bits; stop bit, freq test bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      write_halt <= 1'b0;
      read_freeze <= 1'b0;
      timebase_stop <= 1'b0;
      freq_test <= 1'b0;
    end else if (wr_start) begin
      if (addr == REG_CONTROL) begin
        write_halt <= data_in[BIT_WRITE_HALT];
        read_freeze <= data_in[BIT_READ_FREEZE];
      end
      if (addr == REG_SECONDS) begin
        timebase_stop <= data_in[BIT_TIMEBASE_STOP];
      end
      // battery bit is not writable; only freq test is stored
      if (addr == REG_WEEKDAY) begin
        freq_test <= data_in[BIT_FREQ_TEST];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      test_phase <= 1'b0;
    end else if (!freq_test || timebase_stop) begin
      test_phase <= 1'b0;
    end else if (test_tick) begin
      test_phase <= !test_phase;
    end
  end

  // ram write; address assumed stable through the write
  always_ff @(posedge clock) begin
    if (wr_start && addr < REG_CONTROL) begin
      ram[addr] <= data_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data mux
  logic [7:0] read_value;
  // clock registers in the top eight addresses
  always_comb begin
    case (addr)
      REG_CONTROL: read_value = {write_halt, read_freeze,
                                 visible.century[5:0]};
      REG_SECONDS: read_value = {timebase_stop, visible.seconds[6:1],
                                 visible.seconds[0] ^ test_phase};
      REG_MINUTES: read_value = visible.minutes;
      REG_HOUR: read_value = visible.hour;
      // battery flag in day bit 7
      REG_WEEKDAY: read_value = {battery_good, freq_test, 3'b000,
                                 visible.weekday[2:0]};
      REG_DATE: read_value = visible.date;
      REG_MONTH: read_value = visible.month;
      REG_YEAR: read_value = visible.year;
      default: read_value = ram[addr];
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // access timing
  localparam int TW = 6;
  logic [TW-1:0] addr_age, sel_age, drv_age, hold_age;
  logic [10:0] addr_d;
  access_e acc_state;
  logic addr_changed;
  logic outputs_on;
  assign addr_changed = (addr != addr_d);
  assign outputs_on = sel_ok && !drive_n && !(strobe_n == 1'b0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr_d <= '0;
      addr_age <= '0;
      sel_age <= '0;
      drv_age <= '0;
    end else begin
      addr_d <= addr;
      addr_age <= addr_changed ? '0 :
        (addr_age == '1 ? addr_age : addr_age + TW'(1));
      sel_age <= !sel_ok ? '0 :
        (sel_age == '1 ? sel_age : sel_age + TW'(1));
      drv_age <= drive_n ? '0 :
        (drv_age == '1 ? drv_age : drv_age + TW'(1));
    end
  end

  logic access_met;
  assign access_met = (addr_age >= TW'(ADDR_TO_DATA_CYC - 1))
    && (sel_age >= TW'(SELECT_TO_DATA_CYC - 1))
    && (drv_age >= TW'(DRIVE_TO_DATA_CYC - 1)) && !addr_changed;

  // ripple through: address, select and drive delays all gate the data, no strobe edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_state <= ACC_IDLE;
      hold_age <= '0;
      data_out <= '0;
      data_oe_n <= 1'b1;
    end else if (!rd_mode) begin
      // strobe low floats the outputs; power fail floats them
      acc_state <= ACC_IDLE;
      data_oe_n <= 1'b1;
      data_out <= '0;
    end else begin
      data_oe_n <= 1'b0;
      case (acc_state)
        ACC_IDLE, ACC_WAIT: begin
          // undefined data until the access completes
          data_out <= access_met ? read_value : UNDEF_DATA;
          acc_state <= access_met ? ACC_VALID : ACC_WAIT;
        end
        ACC_VALID: begin
          if (addr_changed) begin
            hold_age <= '0;
            acc_state <= ACC_HOLD;
          end else begin
            data_out <= read_value;
          end
        end
        ACC_HOLD: begin
          // keep old data for the hold time, then undefined
          hold_age <= hold_age + TW'(1);
          if (hold_age >= TW'(OLD_DATA_HOLD_CYC - 1)) begin
            data_out <= UNDEF_DATA;
            acc_state <= ACC_WAIT;
          end
        end
        default: acc_state <= ACC_IDLE;
      endcase
    end
  end

endmodule : rtc_nvram

// ### core/rtc_pkg.sv
// constants and types for the bytewide clock and nonvolatile ram block
// Functional notes
// - eight bcd clock registers occupy addresses 7F8 to 7FF in ascending order
// - no calibration register or trim logic exists
// - read when select low, drive low and write strobe high
// - a new address while selected yields its data without strobe edges
// - data valid one address access delay after the last address change
// - late select or drive: data valid after the later access delay
// - outputs enabled early show undefined data until address delay ends
// - on address change old data holds briefly, then undefined until access
// - write when select and strobe low; starts at the later falling edge
// - drive low before strobe falls gives read data, floats after strobe
// - power fail ignores all accesses and leaves data lines undriven
// - on backup power time keeps counting and ram is retained
// - day register bit 7 reads 1 for good battery, 0 exhausted
// - host writes to the battery flag bit are ignored
// - control bit 6 freezes visible time; refresh within a second after clear
// - control bit 7 halts updates for loading; clear with bit 6 also clear transfers to counters
// - seconds bit 7 set stops the oscillator, clear restarts it
// - freq test with oscillator running toggles seconds lsb at 512 Hz
package rtc_pkg;

  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam logic [10:0] REG_CONTROL = 11'h7F8;
  localparam logic [10:0] REG_SECONDS = 11'h7F9;
  localparam logic [10:0] REG_MINUTES = 11'h7FA;
  localparam logic [10:0] REG_HOUR = 11'h7FB;
  localparam logic [10:0] REG_WEEKDAY = 11'h7FC;
  localparam logic [10:0] REG_DATE = 11'h7FD;
  localparam logic [10:0] REG_MONTH = 11'h7FE;
  localparam logic [10:0] REG_YEAR = 11'h7FF;

  localparam int BIT_WRITE_HALT = 7;
  localparam int BIT_READ_FREEZE = 6;
  localparam int BIT_TIMEBASE_STOP = 7;
  localparam int BIT_BATTERY_OK = 7;
  localparam int BIT_FREQ_TEST = 6;

  // field masks: unused bits are stored as zero
  localparam logic [7:0] MASK_CENTURY = 8'h3F;
  localparam logic [7:0] MASK_SECONDS = 8'h7F;
  localparam logic [7:0] MASK_MINUTES = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h1F;

  localparam int CLOCK_HZ = 200_000_000;
  localparam int TEST_HZ = 512;
  localparam int TEST_HALF_CYCLES = CLOCK_HZ / (2 * TEST_HZ);
  localparam int SECOND_CYCLES = CLOCK_HZ;

  // access delays in ns, access rounds up to whole 5 ns cycles
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int ADDR_TO_DATA_NS = 70;
  localparam int SELECT_TO_DATA_NS = 70;
  localparam int DRIVE_TO_DATA_NS = 35;
  localparam int OLD_DATA_HOLD_NS = 5;
  localparam int ADDR_TO_DATA_CYC =
    (ADDR_TO_DATA_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SELECT_TO_DATA_CYC =
    (SELECT_TO_DATA_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DRIVE_TO_DATA_CYC =
    (DRIVE_TO_DATA_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int OLD_DATA_HOLD_CYC =
    (OLD_DATA_HOLD_NS / CLOCK_PERIOD_NS) < 1 ? 1 :
    (OLD_DATA_HOLD_NS / CLOCK_PERIOD_NS);

  localparam logic [7:0] UNDEF_DATA = 8'hFF;

  typedef struct packed {
    logic [7:0] century;
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hour;
    logic [7:0] weekday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } time_s;

  localparam time_s TIME_RESET = '{century: 8'h20, seconds: 8'h00,
    minutes: 8'h00, hour: 8'h00, weekday: 8'h01, date: 8'h01,
    month: 8'h01, year: 8'h00};

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_WAIT = 2'b01,
    ACC_VALID = 2'b10,
    ACC_HOLD = 2'b11
  } access_e;

endpackage : rtc_pkg

// ### core/rate_divider.sv
// one-cycle enable pulse every PERIOD clock cycles while enabled
module rate_divider #(
  parameter int PERIOD = 200_000_000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  output logic pulse
);
  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] count;

  initial begin
    if (PERIOD < 2) begin
      $error("rate_divider period too small");
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      pulse <= 1'b0;
    end else if (!run) begin
      pulse <= 1'b0;
    end else if (count == LAST) begin
      count <= '0;
      pulse <= 1'b1;
    end else begin
      count <= count + CW'(1);
      pulse <= 1'b0;
    end
  end
endmodule : rate_divider

// ### core/bcd_step.sv
// one bcd digit pair incrementer with wrap from max to min
module bcd_step (
  input wire logic [7:0] value,
  input wire logic [7:0] max_value,
  input wire logic [7:0] min_value,
  output logic [7:0] next_value,
  output logic wrap
);
  always_comb begin
    wrap = (value >= max_value);
    if (wrap) begin
      next_value = min_value;
    end else if (value[3:0] >= 4'h9) begin
      next_value = {value[7:4] + 4'h1, 4'h0};
    end else begin
      next_value = {value[7:4], value[3:0] + 4'h1};
    end
  end
endmodule : bcd_step

// ### testbench/rtc_nvram_sva.sv
// concurrent checks on the bytewide clock and ram port
module rtc_nvram_sva #(
  parameter int SECOND_PERIOD = rtc_pkg::SECOND_CYCLES,
  parameter int TEST_PERIOD = rtc_pkg::TEST_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [rtc_pkg::ADDR_W-1:0] addr,
  input wire logic select_n,
  input wire logic drive_n,
  input wire logic strobe_n,
  input wire logic [rtc_pkg::DATA_W-1:0] data_in,
  input wire logic [rtc_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  input wire logic power_fail,
  input wire logic battery_good
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic rd;
  // consecutive read cycles, saturating; replaces a long repetition
  logic [4:0] rd_run;
  assign rd = !select_n && !drive_n && strobe_n && !power_fail;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_run <= 5'h00;
    end else if (!rd) begin
      rd_run <= 5'h00;
    end else if (rd_run != 5'h1F) begin
      rd_run <= rd_run + 5'h01;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence sel_start;
    $fell(select_n) && rd;
  endsequence
  // a move in mid-read: old value briefly, then the undefined pattern
  sequence addr_move;
    rd && $past(rd) && $changed(addr);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_read_drive: assert property (rd |=> !data_oe_n)
    else $error("output enable did not follow a read");
  a_idle_float: assert property (!rd |=> data_oe_n)
    else $error("outputs driven outside a read");
  a_fail_float: assert property (power_fail |=> data_oe_n)
    else $error("outputs driven during power fail");
  a_float_zero: assert property (data_oe_n |-> data_out == 8'h00)
    else $error("floating data lines not at zero");
  a_sel_undef: assert property (
    sel_start ##1 rd [*7] |-> data_out == UNDEF_DATA)
    else $error("data shown before select access delay");
  a_sel_valid: assert property (
    rd && rd_run == 5'h10 |-> data_out != UNDEF_DATA)
    else $error("data still undefined after access delay");
  a_addr_hold: assert property (addr_move |=> $stable(data_out))
    else $error("old data not held after address change");
  a_addr_undef: assert property (
    addr_move |-> ##3 (data_out == UNDEF_DATA) [*6])
    else $error("new data shown before address access delay");
  a_write_float: assert property (
    $fell(strobe_n) && !select_n && !drive_n |=> data_oe_n)
    else $error("outputs not released after write strobe");
endmodule : rtc_nvram_sva

bind rtc_nvram rtc_nvram_sva #(
  .SECOND_PERIOD(SECOND_PERIOD), .TEST_PERIOD(TEST_PERIOD)
) rtc_nvram_sva_inst (.clock(clock), .rst_n(rst_n), .addr(addr),
  .select_n(select_n), .drive_n(drive_n), .strobe_n(strobe_n),
  .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
  .power_fail(power_fail), .battery_good(battery_good));

// ### testbench/rtc_host_model.sv
// host side model driving the bytewide strobes
module rtc_host_model (
  input wire logic clock,
  input wire logic [rtc_pkg::DATA_W-1:0] data_out,
  output logic [rtc_pkg::ADDR_W-1:0] addr,
  output logic select_n,
  output logic drive_n,
  output logic strobe_n,
  output logic [rtc_pkg::DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  initial begin
    addr = '0;
    select_n = 1'b1;
    drive_n = 1'b1;
    strobe_n = 1'b1;
    data_in = 8'h00;
  end
  // address and data held across the write
  task automatic write_byte(input logic [10:0] a, input logic [7:0] d,
                            input logic keep_drive);
    @(posedge clock);
    #1;
    addr = a;
    data_in = d;
    select_n = 1'b0;
    drive_n = ~keep_drive;
    strobe_n = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    strobe_n = 1'b1;
    select_n = 1'b1;
    drive_n = 1'b1;
    @(posedge clock);
    #1;
    data_in = ~data_in;
  endtask : write_byte
  // select stays low between reads so a new address ripples through
  task automatic read_byte(input logic [10:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    addr = a;
    select_n = 1'b0;
    drive_n = 1'b0;
    repeat (17) @(posedge clock);
    #1;
    d = data_out;
  endtask : read_byte
  task automatic release_bus();
    @(posedge clock);
    #1;
    select_n = 1'b1;
    drive_n = 1'b1;
  endtask : release_bus
  // sustained read: count changes of the lowest data line
  task automatic watch(input int n, output int tog);
    logic p;
    p = data_out[0];
    tog = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (data_out[0] !== p) tog++;
      p = data_out[0];
    end
  endtask : watch
endmodule : rtc_host_model

// ### testbench/tb.sv
// self-checking bench for the bytewide clock and ram block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_pkg::*;
  logic clock, rst_n, power_fail, battery_good, select_n, drive_n;
  logic strobe_n, data_oe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_in, data_out;
  int n_mismatch = 0;
  int checked = 0;
  // a short second keeps rollover tests quick
  rtc_nvram #(.SECOND_PERIOD(64), .TEST_PERIOD(4)) rtc_nvram_inst (
    .clock(clock), .rst_n(rst_n), .addr(addr), .select_n(select_n),
    .drive_n(drive_n), .strobe_n(strobe_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .power_fail(power_fail),
    .battery_good(battery_good));
  rtc_host_model rtc_host_model_inst (.clock(clock), .data_out(data_out),
    .addr(addr), .select_n(select_n), .drive_n(drive_n),
    .strobe_n(strobe_n), .data_in(data_in));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : check
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v == 8'h99) return 8'h00;
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc
  function automatic logic [7:0] last_date(input logic [7:0] m, y);
    int yy;
    yy = y[7:4] * 10 + y[3:0];
    case (m)
      8'h02: return (yy % 4 == 0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : last_date
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    logic [7:0] d, m, y, c, got, s1, ed, em, ey;
    logic [7:0] ram [8];
    logic [10:0] ra [8];
    logic [7:0] wv [7];
    logic [7:0] ex [6];
    logic wrap;
    int tog, mm;
    rst_n = 1'b0;
    power_fail = 1'b0;
    battery_good = 1'b1;
    void'($urandom(97813));
    repeat (6) @(posedge clock);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      ra[i] = 11'(i * 200 + $urandom % 200);
      ram[i] = 8'($urandom % 255);
      rtc_host_model_inst.write_byte(ra[i], ram[i], i[0]);
    end
    for (int i = 0; i < 8; i++) begin
      rtc_host_model_inst.read_byte(ra[i], got);
      check(got, ram[i]);
    end
    ram[0] = ~ram[0] & 8'h7F;
    rtc_host_model_inst.write_byte(ra[0], ram[0], 1'b1);
    rtc_host_model_inst.read_byte(ra[0], got);
    check(got, ram[0]);
    rtc_host_model_inst.release_bus();
    power_fail = 1'b1;
    rtc_host_model_inst.write_byte(ra[1], ~ram[1], 1'b0);
    rtc_host_model_inst.read_byte(ra[1], got);
    check({7'h00, data_oe_n}, 8'h01);
    rtc_host_model_inst.release_bus();
    power_fail = 1'b0;
    rtc_host_model_inst.read_byte(ra[1], got);
    check(got, ram[1]);
    rtc_host_model_inst.release_bus();
    // last second of a day, month or year, then one tick
    for (int r = 0; r < 4; r++) begin
      mm = $urandom % 12 + 1;
      m = (r == 3) ? ((mm > 9) ? 8'(mm + 6) : 8'(mm)) : 8'h02;
      y = (r == 3) ? {4'($urandom % 10), 4'($urandom % 10)} : 8'h01;
      d = 8'h28;
      if (r == 1) y = 8'h04;
      if (r == 2) {m, d, y} = {8'h12, 8'h31, 8'h99};
      if (r == 3) d = last_date(m, y);
      battery_good = 1'($urandom);
      wv = '{8'h59, 8'h59, 8'h23, {~battery_good, 7'h07}, d, m, y};
      rtc_host_model_inst.write_byte(REG_CONTROL, 8'h80, 1'b0);
      rtc_host_model_inst.write_byte(REG_CONTROL, 8'hA0, 1'b0);
      for (int k = 0; k < 7; k++) begin
        rtc_host_model_inst.write_byte(REG_SECONDS + 11'(k), wv[k], 1'b0);
      end
      rtc_host_model_inst.write_byte(REG_CONTROL, 8'h20, 1'b0);
      repeat (66) @(posedge clock);
      wrap = (d == last_date(m, y));
      ed = wrap ? 8'h01 : bcd_inc(d);
      em = !wrap ? m : (m == 8'h12) ? 8'h01 : bcd_inc(m);
      ey = (wrap && m == 8'h12) ? bcd_inc(y) : y;
      c = (ey == 8'h00 && y == 8'h99) ? 8'h21 : 8'h20;
      ex = '{8'h00, 8'h00, {battery_good, 7'h01}, ed, em, ey};
      rtc_host_model_inst.write_byte(REG_CONTROL, {2'b01, c[5:0]}, 1'b0);
      rtc_host_model_inst.read_byte(REG_SECONDS, s1);
      check(s1 & 8'hFE, 8'h00);
      for (int k = 0; k < 6; k++) begin
        rtc_host_model_inst.read_byte(REG_MINUTES + 11'(k), got);
        check(got, ex[k]);
      end
      rtc_host_model_inst.read_byte(REG_CONTROL, got);
      check(got, {2'b01, c[5:0]});
      rtc_host_model_inst.read_byte(REG_SECONDS, got);
      check(got, s1);
      rtc_host_model_inst.write_byte(REG_CONTROL, {2'b00, c[5:0]}, 1'b0);
    end
    rtc_host_model_inst.write_byte(REG_WEEKDAY, 8'h41, 1'b0);
    rtc_host_model_inst.read_byte(REG_SECONDS, got);
    rtc_host_model_inst.watch(64, tog);
    check(8'(tog >= 14 && tog <= 18), 8'h01);
    rtc_host_model_inst.write_byte(REG_SECONDS, 8'h80, 1'b0);
    rtc_host_model_inst.read_byte(REG_SECONDS, got);
    check(got & 8'h80, 8'h80);
    rtc_host_model_inst.watch(140, tog);
    check(8'(tog), 8'h00);
    rtc_host_model_inst.write_byte(REG_SECONDS, 8'h00, 1'b0);
    rtc_host_model_inst.read_byte(REG_SECONDS, got);
    rtc_host_model_inst.watch(64, tog);
    check(8'(tog >= 14), 8'h01);
    rtc_host_model_inst.write_byte(REG_WEEKDAY, 8'h01, 1'b0);
    give_verdict();
  end
endmodule : tb
